// ==== rtl/hie_irq_enable_mask.sv ====
`timescale 1ns/1ps

// Notes on behaviour
// - Interrupt needs status, enable and master enable
// - Enable bit matches status bit position
// - Set view: ones set, zeros keep
// - Set view read returns enable mask
// - Clear view: ones clear, zeros keep
// - Clear view read returns same mask
// - Bit 31 set view: one enables master
// - Bit 31 clear view: one disables master
// - Master enable resets to zero
// - Event enable positions 6,5,4,3,2,0
// - Other mask bits reserved, no effect
// - Set view codes 04H read, 84H write
// - Clear view codes 05H read, 85H write
// - Clear view positions match set view
// - Hardware sets status, software clears ones
// - Frame overflow on counter MSB change
// - Start of frame flagged each frame
module hie_irq_enable_mask
  import hie_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic soft_rst,
  // Bus command and read answer
  input wire hie_cmd_t cmd,
  output hie_rsp_t rsp,
  // Event sources
  input wire hie_event_t events,
  // Interrupt request towards the host bus
  output logic irq_req,
  output logic [31:0] enable_mask,
  output logic [31:0] event_status
);

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [31:0] mask;
    logic [31:0] status;
    logic fmsb_prev;
    logic fmsb_seen;
    hie_rsp_t rsp;
  } hie_state_t;

  hie_state_t st_ff;
  hie_state_t nxt_st;

  // Code match on a valid command
  function automatic logic cmd_is(input hie_cmd_t c, input logic [7:0] code);
    cmd_is = c.valid && (c.code == code);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next state

  // Event set pulses for this cycle
  logic [31:0] ev_set;
  logic fmsb_toggle;

  always_comb begin
    // Only a change seen after the first sampled cycle counts as overflow
    fmsb_toggle = st_ff.fmsb_seen && (events.frame_msb != st_ff.fmsb_prev);
    ev_set = '0;
    ev_set[BIT_ROOT_HUB_CHANGE] = events.root_hub_change;
    ev_set[BIT_FRAME_NUMBER_OVERFLOW] = fmsb_toggle;
    ev_set[BIT_UNRECOVERABLE_ERROR] = events.unrecoverable_error;
    ev_set[BIT_RESUME_DETECTED] = events.resume_detected;
    ev_set[BIT_START_OF_FRAME] = events.start_of_frame;
    ev_set[BIT_SCHED_OVERRUN] = events.sched_overrun;
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.fmsb_prev = events.frame_msb;
    nxt_st.fmsb_seen = 1'b1;
    nxt_st.rsp.valid = 1'b0;
    nxt_st.rsp.data = READ_IDLE;

    // Set view: ones set, reserved bits never stored
    if (cmd_is(cmd, CMD_SET_VIEW_WR)) begin
      nxt_st.mask = st_ff.mask | (cmd.wdata & MASK_BITS);
    end else if (cmd_is(cmd, CMD_CLR_VIEW_WR)) begin
      nxt_st.mask = st_ff.mask & ~(cmd.wdata & MASK_BITS);
    end

    // Status: software write-one-to-clear, hardware set wins in the same cycle
    if (cmd_is(cmd, CMD_STATUS_WR)) begin
      nxt_st.status = (st_ff.status & ~(cmd.wdata & EVENT_BITS)) | ev_set;
    end else begin
      nxt_st.status = st_ff.status | ev_set;
    end

    // Reads answer one cycle later; both views show the one mask
    if (cmd_is(cmd, CMD_SET_VIEW_RD)) begin
      nxt_st.rsp.valid = 1'b1;
      nxt_st.rsp.data = st_ff.mask;
    end else if (cmd_is(cmd, CMD_CLR_VIEW_RD)) begin
      nxt_st.rsp.valid = 1'b1;
      nxt_st.rsp.data = st_ff.mask;
    end else if (cmd_is(cmd, CMD_STATUS_RD)) begin
      nxt_st.rsp.valid = 1'b1;
      nxt_st.rsp.data = st_ff.status;
    end else if (cmd.valid && !cmd.code[7]) begin
      // Unknown read code still answers, with zero, so the bus never hangs
      nxt_st.rsp.valid = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  // Hardware and software reset both clear mask and status.
  // The master enable comes out of reset cleared, so no request can
  // reach the host before software has written the set view once.
  // Trade-off: a driver that relies on the master enable being set
  // after reset must write bit 31 itself.
  always_ff @(posedge core_clk) begin
    if (sys_rst || soft_rst) begin
      st_ff.mask <= MASK_RESET;
      st_ff.status <= STATUS_RESET;
      st_ff.fmsb_prev <= 1'b0;
      st_ff.fmsb_seen <= 1'b0;
      st_ff.rsp.valid <= 1'b0;
      st_ff.rsp.data <= READ_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  // Request is combinational from registered state so clears take effect at once
  assign irq_req = st_ff.mask[BIT_MASTER_IRQ_ENABLE] && |(st_ff.status & st_ff.mask & EVENT_BITS);
  assign rsp = st_ff.rsp;
  assign enable_mask = st_ff.mask;
  assign event_status = st_ff.status;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst || soft_rst);

  sequence seq_set_write;
    cmd.valid && cmd.code == CMD_SET_VIEW_WR;
  endsequence

  sequence seq_clr_write;
    cmd.valid && cmd.code == CMD_CLR_VIEW_WR;
  endsequence

  sequence seq_any_mask_read;
    cmd.valid && (cmd.code == CMD_SET_VIEW_RD || cmd.code == CMD_CLR_VIEW_RD);
  endsequence

  a_set_view_write: assert property (
    seq_set_write |=> enable_mask == ($past(enable_mask) | ($past(cmd.wdata) & MASK_BITS)))
    else $error("set view write did not OR into mask");

  a_clr_view_write: assert property (
    seq_clr_write |=> enable_mask == ($past(enable_mask) & ~($past(cmd.wdata) & MASK_BITS)))
    else $error("clear view write did not clear mask bits");

  a_master_set_irq: assert property (
    (seq_set_write ##0 cmd.wdata[31]) |=> enable_mask[31])
    else $error("master enable not set by set view");

  a_master_clr_irq: assert property (
    (seq_clr_write ##0 cmd.wdata[31]) |=> !irq_req && !enable_mask[31])
    else $error("master disable left request active");

  a_mask_read_back: assert property (
    seq_any_mask_read |=> rsp.valid && rsp.data == $past(enable_mask))
    else $error("mask read returned wrong value");

  a_irq_needs_three: assert property (
    irq_req |-> enable_mask[31] && |(event_status & enable_mask & EVENT_BITS))
    else $error("request without all three conditions");

  a_irq_drop_clear: assert property (
    (cmd.valid && cmd.code == CMD_STATUS_WR && cmd.wdata == 32'hFFFF_FFFF && !(|ev_set)) |=> !irq_req)
    else $error("request stayed after status clear");

  a_reserved_stay_zero: assert property (
    (enable_mask & ~MASK_BITS) == 32'h0000_0000 && (event_status & ~EVENT_BITS) == 32'h0000_0000)
    else $error("reserved bit became set");

  a_status_no_hw_clear: assert property (
    !(cmd.valid && cmd.code == CMD_STATUS_WR) |=> (event_status & $past(event_status)) == $past(event_status))
    else $error("status bit cleared without software write");

  a_fno_on_msb_flip: assert property (
    (st_ff.fmsb_seen && $changed(events.frame_msb)) |=> event_status[5])
    else $error("frame overflow not flagged on MSB change");

  a_sof_flagged: assert property (
    events.start_of_frame |=> event_status[2])
    else $error("start of frame not flagged");

  ////////////////////////////////////////////////////////////////////////
  // Read path: every read answers one cycle later, idle data is zero

  sequence seq_any_read;
    cmd.valid && !cmd.code[7];
  endsequence

  sequence seq_status_write;
    cmd.valid && cmd.code == CMD_STATUS_WR;
  endsequence

  a_read_answers: assert property (
    seq_any_read |=> rsp.valid)
    else $error("read got no answer");

  a_write_no_answer: assert property (
    (cmd.valid && cmd.code[7]) |=> !rsp.valid)
    else $error("write produced a read answer");

  a_rsp_idle_zero: assert property (
    !rsp.valid |-> rsp.data == READ_IDLE)
    else $error("idle read data not zero");

  a_clr_read_back: assert property (
    (cmd.valid && cmd.code == CMD_CLR_VIEW_RD) |=> rsp.data == $past(enable_mask))
    else $error("clear view read not the shared mask");

  a_status_read_back: assert property (
    (cmd.valid && cmd.code == CMD_STATUS_RD) |=> rsp.data == $past(event_status))
    else $error("status read returned wrong value");

  // Unknown read codes still answer so a host poll never hangs
  a_unknown_read_zero: assert property (
    (cmd.valid && !cmd.code[7] && cmd.code != CMD_STATUS_RD && cmd.code != CMD_SET_VIEW_RD
      && cmd.code != CMD_CLR_VIEW_RD) |=> rsp.valid && rsp.data == READ_IDLE)
    else $error("unknown read code not answered with zero");

  ////////////////////////////////////////////////////////////////////////
  // Mask path: each view only moves bits one way

  a_set_keeps_master: assert property (
    (seq_set_write ##0 !cmd.wdata[31]) |=> enable_mask[31] == $past(enable_mask[31]))
    else $error("set view zero changed master enable");

  a_clr_keeps_master: assert property (
    (seq_clr_write ##0 !cmd.wdata[31]) |=> enable_mask[31] == $past(enable_mask[31]))
    else $error("clear view zero changed master enable");

  a_set_never_clears: assert property (
    seq_set_write |=> (enable_mask & $past(enable_mask)) == $past(enable_mask))
    else $error("set view cleared a bit");

  a_clr_never_sets: assert property (
    seq_clr_write |=> (enable_mask & ~$past(enable_mask)) == 32'h0000_0000)
    else $error("clear view set a bit");

  // Reads and status writes must leave the mask alone
  a_mask_hold_idle: assert property (
    !(cmd.valid && (cmd.code == CMD_SET_VIEW_WR || cmd.code == CMD_CLR_VIEW_WR)) |=> $stable(enable_mask))
    else $error("mask moved without a mask write");

  ////////////////////////////////////////////////////////////////////////
  // Event path: each source lands at its own status position

  a_rhc_flagged: assert property (
    events.root_hub_change |=> event_status[6])
    else $error("root hub change not flagged");

  a_uerr_flagged: assert property (
    events.unrecoverable_error |=> event_status[4])
    else $error("unrecoverable error not flagged");

  a_resume_flagged: assert property (
    events.resume_detected |=> event_status[3])
    else $error("resume not flagged");

  a_overrun_flagged: assert property (
    events.sched_overrun |=> event_status[0])
    else $error("scheduling overrun not flagged");

  // A status bit may only appear from an event of the cycle before
  a_status_only_events: assert property (
    (event_status & ~$past(event_status) & ~$past(ev_set)) == 32'h0000_0000)
    else $error("status bit set without an event");

  // Software clear works, except where an event wins the same cycle
  a_status_w1c: assert property (
    seq_status_write |=> (event_status & $past(cmd.wdata) & ~$past(ev_set) & EVENT_BITS) == 32'h0000_0000)
    else $error("status bit not cleared by software");

  ////////////////////////////////////////////////////////////////////////
  // Request: both directions of the three-way condition

  a_irq_when_qualified: assert property (
    (enable_mask[31] && |(event_status & enable_mask & EVENT_BITS)) |-> irq_req)
    else $error("request missing with all conditions met");

  a_irq_master_gate: assert property (
    !enable_mask[31] |-> !irq_req)
    else $error("request without master enable");

endmodule

// ==== rtl/hie_pkg.sv ====
package hie_pkg;

  // Command codes on the shared parallel bus; bit 7 marks a write
  localparam logic [7:0] CMD_STATUS_RD = 8'h03;
  localparam logic [7:0] CMD_STATUS_WR = 8'h83;
  localparam logic [7:0] CMD_SET_VIEW_RD = 8'h04;
  localparam logic [7:0] CMD_SET_VIEW_WR = 8'h84;
  localparam logic [7:0] CMD_CLR_VIEW_RD = 8'h05;
  localparam logic [7:0] CMD_CLR_VIEW_WR = 8'h85;

  // Bit positions of both enable views; all but bit 31 also in the status word
  localparam int BIT_MASTER_IRQ_ENABLE = 31;
  localparam int BIT_ROOT_HUB_CHANGE = 6;
  localparam int BIT_FRAME_NUMBER_OVERFLOW = 5;
  localparam int BIT_UNRECOVERABLE_ERROR = 4;
  localparam int BIT_RESUME_DETECTED = 3;
  localparam int BIT_START_OF_FRAME = 2;
  localparam int BIT_SCHED_OVERRUN = 0;

  // Implemented bits: six events, plus the master enable in the mask
  localparam logic [31:0] EVENT_BITS = 32'h0000_007D;
  localparam logic [31:0] MASK_BITS = 32'h8000_007D;

  // Reset values
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] READ_IDLE = 32'h0000_0000;

  // One bus command, valid for a single cycle
  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic [31:0] wdata;
  } hie_cmd_t;

  // Read answer
  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } hie_rsp_t;

  // Event sources from frame, root-hub and error logic
  typedef struct packed {
    logic root_hub_change;
    logic frame_msb;
    logic unrecoverable_error;
    logic resume_detected;
    logic start_of_frame;
    logic sched_overrun;
  } hie_event_t;

endpackage

// ==== verification/hie_host_model.sv ====
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Host side of the command bus: one strobe per command, launched at the falling edge
module hie_host_model
  import hie_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Command towards the block
  output hie_cmd_t cmd
);
  initial cmd = '0;

  // Idle data is inverted so a stale word never passes for a fresh one
  task automatic send(input logic [7:0] code, input logic [31:0] wdata);
    @(negedge core_clk);
    cmd <= '{1'b1, code, wdata};
    @(negedge core_clk);
    cmd <= '{1'b0, 8'h00, ~wdata};
  endtask
endmodule

// ==== verification/host_irq_enable_mask_bench.sv ====
`timescale 1ns/1ps

module host_irq_enable_mask_bench
  import hie_pkg::*;
;
  logic core_clk;
  logic sys_rst;
  logic soft_rst;
  logic irq_req;
  hie_cmd_t cmd;
  hie_rsp_t rsp;
  hie_event_t events;
  logic [31:0] enable_mask;
  logic [31:0] event_status;
  logic [31:0] exp_mask;
  logic [31:0] seed_word;
  logic [31:0] notes[$];
  int n_fail = 0;
  int comparisons = 0;
  int seed = 96944;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock at 40 MHz
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  hie_host_model hie_host_model_inst (.core_clk(core_clk), .cmd(cmd));
  hie_irq_enable_mask hie_irq_enable_mask_inst (.core_clk(core_clk), .sys_rst(sys_rst), .soft_rst(soft_rst),
    .cmd(cmd), .rsp(rsp), .events(events), .irq_req(irq_req), .enable_mask(enable_mask),
    .event_status(event_status));

  ////////////////////////////////////////////////////////////////////////////////
  // Comparison, bus helpers and closing
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Reserved bits are never stored, so the expected mask keeps only implemented bits
  task automatic wr(input logic [7:0] code, input logic [31:0] d);
    hie_host_model_inst.send(code, d);
    if (code == CMD_SET_VIEW_WR) exp_mask = exp_mask | (d & MASK_BITS);
    else exp_mask = exp_mask & ~d;
  endtask

  task automatic rd(input logic [7:0] code);
    notes.push_back(exp_mask);
    hie_host_model_inst.send(code, 32'h0000_0000);
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Each answer is matched with the oldest expected word
  always @(negedge core_clk) begin
    if (rsp.valid === 1'b1) begin
      if (notes.size() == 0) chk("unexpected answer", 32'h0000_0000, 32'hffff_ffff);
      else chk("read data", notes.pop_front(), rsp.data);
    end
  end

  // Whole run is about a hundred cycles; this span is far beyond it
  initial begin
    #20us;
    n_fail++;
    results();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    sys_rst = 1'b1;
    soft_rst = 1'b0;
    events = '0;
    exp_mask = MASK_RESET;
    repeat (20) @(negedge core_clk);
    sys_rst = 1'b0;
    rd(CMD_SET_VIEW_RD);
    wr(CMD_SET_VIEW_WR, 32'h8000_0004);
    @(negedge core_clk);
    events.start_of_frame = 1'b1;
    @(negedge core_clk);
    events.start_of_frame = 1'b0;
    chk("irq raised", 32'h0000_0001, {31'h0, irq_req});
    wr(CMD_CLR_VIEW_WR, 32'h0000_0004);
    chk("irq event disabled", 32'h0000_0000, {31'h0, irq_req});
    wr(CMD_SET_VIEW_WR, 32'h0000_0004);
    chk("irq reenabled", 32'h0000_0001, {31'h0, irq_req});
    wr(CMD_CLR_VIEW_WR, 32'h8000_0000);
    chk("irq master off", 32'h0000_0000, {31'h0, irq_req});
    // Counter MSB flip and a hub change set status; software clears all
    events.frame_msb = 1'b1;
    events.root_hub_change = 1'b1;
    @(negedge core_clk);
    events.root_hub_change = 1'b0;
    chk("status events", 32'h0000_0064, event_status);
    notes.push_back(32'h0000_0064);
    hie_host_model_inst.send(CMD_STATUS_RD, 32'h0000_0000);
    hie_host_model_inst.send(CMD_STATUS_WR, 32'hffff_ffff);
    chk("status cleared", 32'h0000_0000, event_status);
    wr(CMD_SET_VIEW_WR, 32'h8000_0010);
    events.unrecoverable_error = 1'b1;
    @(negedge core_clk);
    events.unrecoverable_error = 1'b0;
    chk("irq on error", 32'h0000_0001, {31'h0, irq_req});
    hie_host_model_inst.send(CMD_STATUS_WR, 32'hffff_ffff);
    chk("irq after status clear", 32'h0000_0000, {31'h0, irq_req});
    // Unknown read code answers zero
    notes.push_back(READ_IDLE);
    hie_host_model_inst.send(8'h07, 32'h0000_0000);
    // Random words through both views, read back through both
    for (int i = 0; i < 12; i++) begin
      seed_word = $random(seed);
      wr(seed_word[9] ? CMD_CLR_VIEW_WR : CMD_SET_VIEW_WR, seed_word);
      rd(i[0] ? CMD_CLR_VIEW_RD : CMD_SET_VIEW_RD);
      chk("enable mask", exp_mask, enable_mask);
    end
    // Software reset clears mask and status
    soft_rst = 1'b1;
    @(negedge core_clk);
    soft_rst = 1'b0;
    exp_mask = MASK_RESET;
    chk("status after reset", STATUS_RESET, event_status);
    rd(CMD_CLR_VIEW_RD);
    repeat (2) @(negedge core_clk);
    chk("pending answers", 32'h0000_0000, 32'(notes.size()));
    results();
  end
endmodule
